/* File: logic/tbah_pkg.sv */
package tbah_pkg;
  localparam logic [7:0] CMD_REQ = 8'h05;
  localparam logic [7:0] CMD_ATTRIB = 8'h1d;
  localparam logic [7:0] RSP_ATQB = 8'h50;
  localparam logic [7:0] RSP_ATTRIB = 8'h10;
  localparam logic [7:0] APP_DATA = 8'h00;
  localparam logic [7:0] PROTO_RATE = 8'h91;
  localparam logic [7:0] PROTO_SIZE = 8'h81;
  localparam logic [3:0] PROTO_TYPE = 4'h1;
  localparam logic [3:0] FWI_RESET = 4'h4;
  localparam int ATQB_LEN = 12;
  localparam int ATTRIB_LEN = 9;
  localparam int REQ_LEN = 3;
  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [1:0] TR_RESERVED = 2'h3;
  localparam logic [1:0] TR_DEFAULT = 2'h0;
  localparam int ETU_NS = 9440;
  localparam int FS_NS = 1180;
  localparam int CLK_NS = 8;
  localparam int TR2_NS = 10 * ETU_NS + 32 * FS_NS;
  localparam int TR2_CYCLES = (TR2_NS + CLK_NS - 1) / CLK_NS;
  localparam int TR0_MIN_FS = 64;
  localparam int TR1_MIN_FS = 80;
  localparam int FIFO_DEPTH = 8;
endpackage

/* File: logic/tbah_if.sv */
`timescale 1ns/1ps
interface tbah_if;
  logic [7:0] rdr_data;
  logic rdr_valid;
  logic rdr_last;
  logic rdr_ready;
  logic [7:0] card_data;
  logic card_valid;
  logic card_last;
  logic card_ready;
  modport card (input rdr_data, rdr_valid, rdr_last, card_ready,
    output rdr_ready, card_data, card_valid, card_last);
  modport reader (output rdr_data, rdr_valid, rdr_last, card_ready,
    input rdr_ready, card_data, card_valid, card_last);
endinterface

/* File: logic/tbah_fifo.sv */
`timescale 1ns/1ps
module tbah_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two");
  end
  if (WIDTH < 1) begin : g_width_check
    $error("WIDTH must be at least one");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic do_wr;
  logic do_rd;
  assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data = mem[rd_reg[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule // tbah_fifo

/* File: logic/tbah_card.sv */
`timescale 1ns/1ps
// Overview of operation
// [R1] Answer request with code, id, data, info, CRC.
// [R2] Four application data bytes sent as zero.
// [R3] First protocol info byte is 0x91.
// [R4] Second info byte upper nibble advertises 256.
// [R5] Second info byte lower nibble is 0001b.
// [R6] Reader waits 10 etu plus 32/fs.
// [R7] Third info byte upper nibble carries FWI.
// [R8] Third info byte bits 3-2 are 00b.
// [R9] Third info byte bits 1-0 are 00b.
// [R10] Selection code 0x1D with matching identifier.
// [R11] Reader encodes TR0 in parameter bits 7-6.
// [R12] Reader encodes TR1 in parameter bits 5-4.
// [R13] Card keeps TR0 64/fs, TR1 80/fs, SOF/EOF; the card times no TR0/TR1, has no SOF/EOF and only outputs the codes.
// [R14] Reserved TR0 or TR1 code treated as 00b.
// [R15] Silent when the two data rates differ.
// [R16] Only listed reader frame sizes are answered.
// [R17] Third parameter lower nibble matches protocol type.
// [R18] Fourth parameter card identifier must be zero.
// [R19] Accepted selection answered with 0x10 plus CRC.
module tbah_card (
  input wire logic clk,
  input wire logic sys_rst,
  tbah_if.card link,
  input wire logic [31:0] pupi,
  input wire logic [3:0] fwi,
  output logic selected,
  output logic [1:0] rate,
  output logic [3:0] rdr_fsize,
  output logic [1:0] tr0_code,
  output logic [1:0] tr1_code
);
  typedef enum logic [1:0] {ST_RX, ST_DECIDE, ST_TX} tbah_state_e;
  tbah_state_e state_reg;
  logic [7:0] buf_reg [tbah_pkg::ATTRIB_LEN];
  logic [3:0] cnt_reg;
  logic [3:0] len_reg;
  logic [3:0] tx_reg;
  logic [3:0] tx_len_reg;
  logic is_attrib_reg;
  logic [15:0] crc_reg;
  logic [7:0] tx_byte;
  logic [8:0] f_in;
  logic f_in_valid;
  logic f_in_ready;
  logic [8:0] f_out;
  logic f_out_valid;
  logic req_ok;
  logic att_ok;
  logic [31:0] rx_id;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] p3;
  logic [7:0] p4;
  logic size_ok;
  logic [1:0] tr0_eff;
  logic [1:0] tr1_eff;
  logic rx_take;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
    end
    return r;
  endfunction

  assign rx_id = {buf_reg[1], buf_reg[2], buf_reg[3], buf_reg[4]};
  assign p1 = buf_reg[5];
  assign p2 = buf_reg[6];
  assign p3 = buf_reg[7];
  assign p4 = buf_reg[8];
  assign tr0_eff = (p1[7:6] == tbah_pkg::TR_RESERVED) ? tbah_pkg::TR_DEFAULT : p1[7:6]; // R14
  assign tr1_eff = (p1[5:4] == tbah_pkg::TR_RESERVED) ? tbah_pkg::TR_DEFAULT : p1[5:4]; // R14
  assign size_ok = p2[3:0] inside {4'h8, 4'h7, 4'h6, 4'h5}; // R16
  assign req_ok = (len_reg == 4'(tbah_pkg::REQ_LEN)) && (buf_reg[0] == tbah_pkg::CMD_REQ);
  assign att_ok = (len_reg == 4'(tbah_pkg::ATTRIB_LEN))
    && (buf_reg[0] == tbah_pkg::CMD_ATTRIB) && (rx_id == pupi) // R10
    && (p2[7:6] == p2[5:4]) && (p2[7:6] <= tbah_pkg::RATE_212) // R15
    && size_ok // R16
    && (p3[3:0] == tbah_pkg::PROTO_TYPE) // R17
    && (p4[3:0] == 4'h0); // R18

  always_comb begin
    tx_byte = tbah_pkg::APP_DATA;
    if (is_attrib_reg) begin
      case (tx_reg)
        4'h0: tx_byte = tbah_pkg::RSP_ATTRIB; // R19
        4'h1: tx_byte = crc_reg[7:0]; // R19
        4'h2: tx_byte = crc_reg[15:8]; // R19
        default: tx_byte = tbah_pkg::APP_DATA;
      endcase
    end else begin
      case (tx_reg)
        4'h0: tx_byte = tbah_pkg::RSP_ATQB; // R1
        4'h1: tx_byte = pupi[31:24]; // R1
        4'h2: tx_byte = pupi[23:16];
        4'h3: tx_byte = pupi[15:8];
        4'h4: tx_byte = pupi[7:0];
        4'h5, 4'h6, 4'h7, 4'h8: tx_byte = tbah_pkg::APP_DATA; // R2
        4'h9: tx_byte = tbah_pkg::PROTO_RATE; // R3
        4'ha: tx_byte = tbah_pkg::PROTO_SIZE; // R4 R5
        4'hb: tx_byte = {fwi, 2'b00, 2'b00}; // R7 R8 R9
        4'hc: tx_byte = crc_reg[7:0];
        4'hd: tx_byte = crc_reg[15:8];
        default: tx_byte = tbah_pkg::APP_DATA;
      endcase
    end
  end

  assign f_in = {(tx_reg == tx_len_reg - 4'h1), tx_byte};
  assign f_in_valid = state_reg == ST_TX;
  assign link.rdr_ready = (state_reg == ST_RX) && !f_out_valid;
  assign rx_take = link.rdr_valid && link.rdr_ready;

  tbah_fifo #(.WIDTH(9), .DEPTH(tbah_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(f_in),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_out_valid),
    .out_ready(link.card_ready)
  );
  assign link.card_data = f_out[7:0];
  assign link.card_last = f_out[8];
  assign link.card_valid = f_out_valid;

  always_ff @(posedge clk) begin
    if (rx_take && cnt_reg < 4'(tbah_pkg::ATTRIB_LEN)) begin
      buf_reg[cnt_reg] <= link.rdr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_RX;
      cnt_reg <= '0;
      len_reg <= '0;
      tx_reg <= '0;
      tx_len_reg <= '0;
      is_attrib_reg <= 1'b0;
      crc_reg <= 16'hffff;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (rx_take) begin
            cnt_reg <= (cnt_reg == 4'hf) ? cnt_reg : cnt_reg + 4'h1;
            if (link.rdr_last) begin
              len_reg <= cnt_reg + 4'h1;
              cnt_reg <= '0;
              state_reg <= ST_DECIDE;
            end
          end
        end
        ST_DECIDE: begin
          tx_reg <= '0;
          crc_reg <= 16'hffff;
          if (req_ok) begin
            is_attrib_reg <= 1'b0;
            tx_len_reg <= 4'(tbah_pkg::ATQB_LEN + 2);
            state_reg <= ST_TX;
          end else if (att_ok) begin
            is_attrib_reg <= 1'b1;
            tx_len_reg <= 4'h3;
            state_reg <= ST_TX;
          end else begin
            state_reg <= ST_RX; // R15 R16 R17 R18
          end
        end
        ST_TX: begin
          if (f_in_ready) begin
            crc_reg <= crc_step(crc_reg, tx_byte);
            if (tx_reg == tx_len_reg - 4'h3) begin
              crc_reg <= ~crc_step(crc_reg, tx_byte);
            end else if (tx_reg > tx_len_reg - 4'h3) begin
              crc_reg <= crc_reg;
            end
            tx_reg <= tx_reg + 4'h1;
            if (tx_reg == tx_len_reg - 4'h1) begin
              state_reg <= ST_RX;
            end
          end
        end
        default: state_reg <= ST_RX;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selected <= 1'b0;
      rate <= tbah_pkg::RATE_106;
      rdr_fsize <= 4'h0;
      tr0_code <= tbah_pkg::TR_DEFAULT;
      tr1_code <= tbah_pkg::TR_DEFAULT;
    end else if (state_reg == ST_DECIDE && att_ok) begin
      selected <= 1'b1;
      rate <= p2[7:6];
      rdr_fsize <= p2[3:0];
      tr0_code <= tr0_eff; // R13
      tr1_code <= tr1_eff; // R13
    end
  end
endmodule // tbah_card

/* File: logic/tbah_reader.sv */
`timescale 1ns/1ps
module tbah_reader #(
  parameter int GAP_CYCLES = tbah_pkg::TR2_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  tbah_if.reader link,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_last
);
  if (GAP_CYCLES < 1) begin : g_gap_check
    $error("GAP_CYCLES must be at least one");
  end
  logic [31:0] gap_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg <= '0;
    end else if (link.card_valid && link.card_last) begin
      gap_reg <= 32'(GAP_CYCLES); // R6
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - 32'h1; // R6
    end
  end
  assign link.rdr_data = cmd_data;
  assign link.rdr_last = cmd_last;
  assign link.rdr_valid = cmd_valid && (gap_reg == '0); // R6
  assign cmd_ready = link.rdr_ready && (gap_reg == '0);
  assign link.card_ready = 1'b1;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
    end else begin
      rsp_data <= link.card_data;
      rsp_valid <= link.card_valid;
      rsp_last <= link.card_last;
    end
  end
endmodule // tbah_reader

/* File: sim/tbah_checker.sv */
`timescale 1ns/1ps
module tbah_checker #(
  parameter int GAP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] rdr_data,
  input wire logic rdr_valid,
  input wire logic rdr_last,
  input wire logic rdr_ready,
  input wire logic [7:0] card_data,
  input wire logic card_valid,
  input wire logic card_last,
  input wire logic card_ready
);
  logic [3:0] idx_reg;
  logic [7:0] code_reg;
  logic [7:0] gap_reg;
  wire logic ctake = card_valid && card_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) idx_reg <= 4'h0;
    else if (ctake) idx_reg <= card_last ? 4'h0 : idx_reg + 4'h1;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) code_reg <= 8'h00;
    else if (ctake && idx_reg == 4'h0) code_reg <= card_data;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) gap_reg <= 8'hff;
    else if (ctake && card_last) gap_reg <= 8'h00;
    else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
  end
  a_card_hold: assert property (ctake && !card_last |=> card_valid)
    else $error("card frame has a hole");
  a_first_code: assert property (ctake && idx_reg == 4'h0 |->
    card_data == tbah_pkg::RSP_ATQB || card_data == tbah_pkg::RSP_ATTRIB)
    else $error("bad response code");
  a_app_zero: assert property (ctake && code_reg == tbah_pkg::RSP_ATQB && idx_reg >= 4'h5 &&
    idx_reg <= 4'h8 |-> card_data == 8'h00) else $error("application byte not zero");
  a_rate_info: assert property (ctake && code_reg == tbah_pkg::RSP_ATQB && idx_reg == 4'h9
    |-> card_data == 8'h91) else $error("first info byte wrong");
  a_size_info: assert property (ctake && code_reg == tbah_pkg::RSP_ATQB && idx_reg == 4'ha
    |-> card_data == 8'h81) else $error("second info byte wrong");
  a_option_bits: assert property (ctake && code_reg == tbah_pkg::RSP_ATQB &&
    idx_reg == 4'hb |-> card_data[3:0] == 4'h0) else $error("third info low nibble not zero");
  a_frame_len: assert property (ctake && card_last |-> idx_reg ==
    (code_reg == tbah_pkg::RSP_ATQB ? 4'hd : 4'h2)) else $error("response length wrong");
  a_reader_gap: assert property ($rose(rdr_valid) |-> int'(gap_reg) >= GAP_CYCLES - 1)
    else $error("reader command too soon");
  a_answer_wait: assert property (rdr_valid && rdr_ready && rdr_last |=> !card_valid
    ##1 !card_valid) else $error("answer came too early");
  a_busy_ready: assert property (card_valid |-> !rdr_ready)
    else $error("card ready while answering");
  logic rmid_reg;
  logic [7:0] cmd_reg;
  wire logic rtake = rdr_valid && rdr_ready;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rmid_reg <= 1'b0;
    else if (rtake) rmid_reg <= !rdr_last;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cmd_reg <= 8'h00;
    else if (rtake && !rmid_reg) cmd_reg <= rdr_data;
  end
  a_atqb_cause: assert property (ctake && idx_reg == 4'h0 &&
    card_data == tbah_pkg::RSP_ATQB |-> cmd_reg == tbah_pkg::CMD_REQ)
    else $error("request answer without request");
  a_attrib_cause: assert property (ctake && idx_reg == 4'h0 &&
    card_data == tbah_pkg::RSP_ATTRIB |-> cmd_reg == tbah_pkg::CMD_ATTRIB)
    else $error("selection answer without selection");
  c_atqb: cover property (ctake && card_last && code_reg == tbah_pkg::RSP_ATQB);
  c_attrib: cover property (ctake && card_last && code_reg == tbah_pkg::RSP_ATTRIB);
  c_command: cover property (rdr_valid && rdr_ready && rdr_last);
endmodule // tbah_checker

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk, sys_rst, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, selected;
  logic [7:0] cmd_data, rsp_data;
  logic [31:0] pupi;
  logic [3:0] fwi, rdr_fsize;
  logic [1:0] rate, tr0_code, tr1_code;
  logic [7:0] e[$];
  logic [7:0] no_rsp[$];
  int bad_count, tests_run;
  tbah_if u_tbah_if();
  tbah_card u_tbah_card(.clk(clk), .sys_rst(sys_rst), .link(u_tbah_if), .pupi(pupi), .fwi(fwi),
    .selected(selected), .rate(rate), .rdr_fsize(rdr_fsize), .tr0_code(tr0_code),
    .tr1_code(tr1_code));
  tbah_reader #(.GAP_CYCLES(4)) u_tbah_reader(.clk(clk), .sys_rst(sys_rst), .link(u_tbah_if),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last));
  tbah_checker #(.GAP_CYCLES(4)) u_tbah_checker(.clk(clk), .sys_rst(sys_rst),
    .rdr_data(u_tbah_if.rdr_data), .rdr_valid(u_tbah_if.rdr_valid),
    .rdr_last(u_tbah_if.rdr_last), .rdr_ready(u_tbah_if.rdr_ready),
    .card_data(u_tbah_if.card_data), .card_valid(u_tbah_if.card_valid),
    .card_last(u_tbah_if.card_last), .card_ready(u_tbah_if.card_ready));
  always #4 clk = ~clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task addcrc(inout logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    c = ~c;
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask
  task xfer(input logic [7:0] f[$], input logic [7:0] x[$]);
    logic r;
    int n;
    foreach (f[i]) begin
      cmd_data <= f[i];
      cmd_last <= (i == f.size() - 1);
      cmd_valid <= 1'b1;
      do begin @(negedge clk); r = cmd_ready; @(posedge clk); end while (r !== 1'b1);
    end
    cmd_valid <= 1'b0;
    n = 0;
    for (int k = 0; k < 60; k++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) begin
        chk(rsp_data, (n < x.size()) ? x[n] : 8'hxx);
        chk(rsp_last, n == x.size() - 1);
        n++;
      end
    end
    @(posedge clk);
    chk(n, x.size());
    $display("transfer of %0d bytes done", f.size());
  endtask
  task att(input logic [31:0] id, input logic [7:0] p1, p2, p3, p4, input bit ok);
    logic [7:0] q[$];
    q = {};
    if (ok) begin q = {8'h10}; addcrc(q); end
    xfer({8'h1d, id[31:24], id[23:16], id[15:8], id[7:0], p1, p2, p3, p4}, q);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    results;
  end
  initial begin
    logic [3:0] s;
    clk = 0; sys_rst = 1; cmd_valid = 0; cmd_last = 0; cmd_data = 8'h00;
    pupi = 32'h1234a5c3; fwi = 4'ha; bad_count = 0; tests_run = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(selected, 1'b0);
    e = {8'h50, 8'h12, 8'h34, 8'ha5, 8'hc3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h91, 8'h81, 8'ha0};
    addcrc(e);
    xfer({8'h05, 8'h00, 8'h00}, e);
    att(32'h1234a5c4, 8'h00, 8'h08, 8'h01, 8'h00, 0);
    att(pupi, 8'h00, 8'h48, 8'h01, 8'h00, 0);
    att(pupi, 8'h00, 8'h04, 8'h01, 8'h00, 0);
    att(pupi, 8'h00, 8'h08, 8'h02, 8'h00, 0);
    att(pupi, 8'h00, 8'h08, 8'h01, 8'h01, 0);
    att(pupi, 8'h00, 8'ha8, 8'h01, 8'h00, 0);
    xfer({8'h05, 8'h00}, no_rsp);
    xfer({8'h06, 8'h00, 8'h00}, no_rsp);
    chk(selected, 1'b0);
    for (int i = 5; i <= 8; i++) begin
      s = i[3:0];
      att(pupi, s[0] ? 8'hff : 8'h60, {1'b0, s[0], 1'b0, s[0], s}, 8'h01, 8'hf0, 1);
      chk(rate, {1'b0, s[0]});
      chk(rdr_fsize, s);
      chk(tr0_code, s[0] ? 2'h0 : 2'h1);
      chk(tr1_code, s[0] ? 2'h0 : 2'h2);
      chk(selected, 1'b1);
    end
    results;
  end
endmodule // tb
